// *** hw/uic_interrupt_fifo_control.sv ***
// Interrupt identification, FIFO control and line format registers of one serial channel.
`default_nettype none
module uic_interrupt_fifo_control (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output logic pready,
    output var logic pslverr,
    input wire uic_pkg::uic_chan_evt_s chanEvt,
    output var uic_pkg::uic_fifo_ctl_s fifoCtl,
    output var logic irqOutput,
    output var logic rxDmaRequest,
    output var logic txDmaRequest
);
    logic [3:0] interruptEnable;
    logic [7:0] lineFormat;
    logic fifoEnable;
    logic dmaModeSelect;
    logic [1:0] triggerSel;
    logic lineStatusPending;
    logic txEmptyPending;
    logic modemPending;
    logic timeoutPending;
    logic txEmptyPrev;
    logic [5:0] idleTicks;
    logic [5:0] timeoutLimit;
    logic [4:0] rxTrigger;
    logic dataCondition;
    logic [3:0] identCode;
    logic [7:0] identValue;
    logic setupPhase;
    logic accessDone;
    logic wrIen;
    logic wrFctl;
    logic wrLfc;
    logic rdIdent;
    logic mapped;

    assign pready = ce;
    assign setupPhase = ce && psel && !penable;
    assign accessDone = ce && psel && penable;
    assign mapped = (paddr == uic_pkg::IEN_ADDR) || (paddr == uic_pkg::IDENT_ADDR) || (paddr == uic_pkg::LFC_ADDR);
    assign wrIen = accessDone && pwrite && (paddr == uic_pkg::IEN_ADDR);
    assign wrFctl = accessDone && pwrite && (paddr == uic_pkg::IDENT_ADDR);
    assign wrLfc = accessDone && pwrite && (paddr == uic_pkg::LFC_ADDR);
    assign rdIdent = accessDone && !pwrite && (paddr == uic_pkg::IDENT_ADDR);

    // Receive trigger level decode.
    always_comb begin
        unique case (triggerSel)
            2'b00: rxTrigger = uic_pkg::TRIG_LVL0;
            2'b01: rxTrigger = uic_pkg::TRIG_LVL1;
            2'b10: rxTrigger = uic_pkg::TRIG_LVL2;
            2'b11: rxTrigger = uic_pkg::TRIG_LVL3;
        endcase
    end

    // Received data condition is a level that drains as the buffer is read.
    always_comb begin
        if (fifoEnable) begin
            dataCondition = chanEvt.rxCount >= rxTrigger;
        end else begin
            dataCondition = chanEvt.rxCount != 5'h00;
        end
    end

    // Four character times in bit periods: start, data, optional parity and stop.
    always_comb begin
        timeoutLimit = 6'(uic_pkg::TIMEOUT_CHARS * (uic_pkg::FRAME_OVERHEAD + 6'(fifoCtl.dataBits)
            + 6'(lineFormat[uic_pkg::LFC_PARITY])));
    end

    // Prioritised identification; lower sources wait behind higher ones.
    always_comb begin
        if (interruptEnable[uic_pkg::IEN_LINE] && lineStatusPending) begin
            identCode = uic_pkg::ID_LINE;
        end else if (interruptEnable[uic_pkg::IEN_DATA] && dataCondition) begin
            identCode = uic_pkg::ID_DATA;
        end else if (interruptEnable[uic_pkg::IEN_DATA] && timeoutPending && fifoEnable) begin
            identCode = uic_pkg::ID_TIMEOUT;
        end else if (interruptEnable[uic_pkg::IEN_TXE] && txEmptyPending) begin
            identCode = uic_pkg::ID_TXEMPTY;
        end else if (interruptEnable[uic_pkg::IEN_MODEM] && modemPending) begin
            identCode = uic_pkg::ID_MODEM;
        end else begin
            identCode = uic_pkg::ID_NONE;
        end
    end

    assign identValue = {fifoEnable, fifoEnable, 2'b00, identCode};

    // Interrupt-enable register; upper bits are not stored.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            interruptEnable <= uic_pkg::IEN_RESET[3:0];
        end else if (ce && wrIen) begin
            interruptEnable <= pwdata[3:0] & uic_pkg::IEN_USED_MASK;
        end
    end

    // Line format register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lineFormat <= uic_pkg::LFC_RESET;
        end else if (ce && wrLfc) begin
            lineFormat <= pwdata[7:0];
        end
    end

    // FIFO control: the enable bit must be one for the other bits to load.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fifoEnable <= 1'b0;
            dmaModeSelect <= 1'b0;
            triggerSel <= 2'b00;
        end else if (ce && wrFctl) begin
            fifoEnable <= pwdata[uic_pkg::FCTL_ENABLE];
            if (pwdata[uic_pkg::FCTL_ENABLE]) begin
                dmaModeSelect <= pwdata[uic_pkg::FCTL_DMA_MODE];
                triggerSel <= pwdata[uic_pkg::FCTL_TRIG_LSB +: 2];
            end
        end
    end

    // One-cycle clear pulses toward the FIFOs and registered copies of the control fields.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fifoCtl.rxClear <= 1'b0;
            fifoCtl.txClear <= 1'b0;
            fifoCtl.fifoEnable <= 1'b0;
            fifoCtl.dmaMode <= 1'b0;
            fifoCtl.rxTrigger <= uic_pkg::TRIG_LVL0;
            fifoCtl.dataBits <= uic_pkg::MIN_DATA_BITS;
            fifoCtl.lineFormat <= uic_pkg::LFC_RESET;
        end else if (ce) begin
            fifoCtl.rxClear <= wrFctl && ((pwdata[uic_pkg::FCTL_ENABLE] != fifoEnable)
                || (pwdata[uic_pkg::FCTL_ENABLE] && pwdata[uic_pkg::FCTL_RX_CLEAR]));
            fifoCtl.txClear <= wrFctl && ((pwdata[uic_pkg::FCTL_ENABLE] != fifoEnable)
                || (pwdata[uic_pkg::FCTL_ENABLE] && pwdata[uic_pkg::FCTL_TX_CLEAR]));
            fifoCtl.fifoEnable <= fifoEnable;
            fifoCtl.dmaMode <= fifoEnable && dmaModeSelect;
            fifoCtl.rxTrigger <= rxTrigger;
            fifoCtl.dataBits <= uic_pkg::MIN_DATA_BITS + {2'b00, lineFormat[1:0]};
            fifoCtl.lineFormat <= lineFormat;
        end
    end

    // Receiver line status: set wins over the clearing read.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lineStatusPending <= 1'b0;
        end else if (ce) begin
            if (chanEvt.lineError) begin
                lineStatusPending <= 1'b1;
            end else if (chanEvt.lineStatusRead) begin
                lineStatusPending <= 1'b0;
            end
        end
    end

    // Modem status: set wins over the clearing read.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            modemPending <= 1'b0;
        end else if (ce) begin
            if (chanEvt.modemChange) begin
                modemPending <= 1'b1;
            end else if (chanEvt.modemStatusRead) begin
                modemPending <= 1'b0;
            end
        end
    end

    // Transmit holding empty: raised when the holder goes empty.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txEmptyPrev <= 1'b0;
            txEmptyPending <= 1'b0;
        end else if (ce) begin
            txEmptyPrev <= chanEvt.txHoldEmpty;
            if (chanEvt.txHoldEmpty && !txEmptyPrev) begin
                txEmptyPending <= 1'b1;
            end else if (chanEvt.txHoldWrite || (rdIdent && identCode == uic_pkg::ID_TXEMPTY)) begin
                txEmptyPending <= 1'b0;
            end
        end
    end

    // Character timeout counts bit periods while the receive FIFO sits idle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idleTicks <= 6'h00;
            timeoutPending <= 1'b0;
        end else if (ce) begin
            if (!fifoEnable || chanEvt.rxPush || chanEvt.rxBufferRead || chanEvt.rxCount == 5'h00) begin
                idleTicks <= 6'h00;
            end else if (chanEvt.bitTick && idleTicks < timeoutLimit) begin
                idleTicks <= idleTicks + 6'h01;
            end
            if (fifoEnable && chanEvt.rxCount != 5'h00 && !chanEvt.rxPush && !chanEvt.rxBufferRead
                && idleTicks >= timeoutLimit) begin
                timeoutPending <= 1'b1;
            end else if (chanEvt.rxBufferRead || !fifoEnable) begin
                timeoutPending <= 1'b0;
            end
        end
    end

    // Interrupt output and DMA requests.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqOutput <= 1'b0;
            rxDmaRequest <= 1'b0;
            txDmaRequest <= 1'b0;
        end else if (ce) begin
            irqOutput <= identCode != uic_pkg::ID_NONE;
            if (fifoEnable && dmaModeSelect) begin
                rxDmaRequest <= dataCondition || timeoutPending;
                txDmaRequest <= !chanEvt.txFifoFull;
            end else begin
                rxDmaRequest <= chanEvt.rxCount != 5'h00;
                txDmaRequest <= chanEvt.txHoldEmpty;
            end
        end
    end

    // APB read data and error are loaded in the setup cycle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            pslverr <= !mapped;
            if (pwrite || !mapped) begin
                prdata <= 32'h0000_0000;
            end else if (paddr == uic_pkg::IEN_ADDR) begin
                prdata <= {28'h000_0000, interruptEnable};
            end else if (paddr == uic_pkg::IDENT_ADDR) begin
                prdata <= {24'h00_0000, identValue};
            end else begin
                prdata <= {24'h00_0000, lineFormat};
            end
        end
    end
endmodule
`default_nettype wire

// *** hw/uic_pkg.sv ***
// Package of offsets, fields, codes and carriers for the serial channel interrupt and FIFO control.
`default_nettype none
package uic_pkg;
    localparam logic [11:0] IEN_ADDR = 12'h004;
    localparam logic [11:0] IDENT_ADDR = 12'h008;
    localparam logic [11:0] LFC_ADDR = 12'h00C;
    localparam logic [7:0] IEN_RESET = 8'h00;
    localparam logic [7:0] LFC_RESET = 8'h00;
    localparam logic [3:0] IEN_USED_MASK = 4'hF;
    localparam int IEN_DATA = 0;
    localparam int IEN_TXE = 1;
    localparam int IEN_LINE = 2;
    localparam int IEN_MODEM = 3;
    localparam int FCTL_ENABLE = 0;
    localparam int FCTL_RX_CLEAR = 1;
    localparam int FCTL_TX_CLEAR = 2;
    localparam int FCTL_DMA_MODE = 3;
    localparam int FCTL_TRIG_LSB = 6;
    localparam int LFC_PARITY = 3;
    localparam logic [3:0] ID_NONE = 4'h1;
    localparam logic [3:0] ID_LINE = 4'h6;
    localparam logic [3:0] ID_DATA = 4'h4;
    localparam logic [3:0] ID_TIMEOUT = 4'hC;
    localparam logic [3:0] ID_TXEMPTY = 4'h2;
    localparam logic [3:0] ID_MODEM = 4'h0;
    localparam logic [4:0] TRIG_LVL0 = 5'h01;
    localparam logic [4:0] TRIG_LVL1 = 5'h04;
    localparam logic [4:0] TRIG_LVL2 = 5'h08;
    localparam logic [4:0] TRIG_LVL3 = 5'h0E;
    localparam logic [3:0] MIN_DATA_BITS = 4'h5;
    localparam logic [5:0] FRAME_OVERHEAD = 6'h02;
    localparam logic [5:0] TIMEOUT_CHARS = 6'h04;

    // Events and levels reported by the rest of the channel, all on clk.
    typedef struct packed {
        logic bitTick;
        logic rxPush;
        logic rxBufferRead;
        logic lineError;
        logic lineStatusRead;
        logic modemChange;
        logic modemStatusRead;
        logic txHoldWrite;
        logic txHoldEmpty;
        logic txFifoFull;
        logic [4:0] rxCount;
    } uic_chan_evt_s;

    // Controls handed to the FIFOs and the shift logic.
    typedef struct packed {
        logic fifoEnable;
        logic rxClear;
        logic txClear;
        logic dmaMode;
        logic [4:0] rxTrigger;
        logic [3:0] dataBits;
        logic [7:0] lineFormat;
    } uic_fifo_ctl_s;
endpackage
`default_nettype wire

// *** sim/uic_chan_model.sv ***
// Model of the channel logic that feeds events and receive fill to the control block.
`default_nettype none
module uic_chan_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [6:0] pulseReq,
    input wire logic txEmpty,
    input wire logic txFull,
    input wire logic rxClear,
    output var uic_pkg::uic_chan_evt_s evt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] tickDiv;
    logic [4:0] fill;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tickDiv <= 2'h0;
            fill <= 5'h00;
        end else begin
            tickDiv <= tickDiv + 2'h1;
            if (rxClear) begin
                fill <= 5'h00;
            end else if (pulseReq[6]) begin
                fill <= fill + 5'h01;
            end else if (pulseReq[5] && fill != 5'h00) begin
                fill <= fill - 5'h01;
            end
        end
    end
    always_comb begin
        evt.bitTick = tickDiv == 2'h3;
        {evt.rxPush, evt.rxBufferRead, evt.lineError, evt.lineStatusRead} = pulseReq[6:3];
        {evt.modemChange, evt.modemStatusRead, evt.txHoldWrite} = pulseReq[2:0];
        evt.txHoldEmpty = txEmpty;
        evt.txFifoFull = txFull;
        evt.rxCount = fill;
    end
endmodule
`default_nettype wire

// *** sim/uic_ifc_chk.sv ***
// Checker of the control block's outputs against its register and FIFO control behaviour.
`default_nettype none
module uic_ifc_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire uic_pkg::uic_fifo_ctl_s fifoCtl,
    input wire logic irqOutput
);
    logic rdId;
    logic rdIe;
    assign rdId = psel && !penable && !pwrite && ce && paddr == uic_pkg::IDENT_ADDR;
    assign rdIe = psel && !penable && !pwrite && ce && paddr == uic_pkg::IEN_ADDR;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_rxclr_self: assert property (fifoCtl.rxClear |=> !fifoCtl.rxClear)
        else $error("receive clear held");
    chk_txclr_self: assert property (fifoCtl.txClear |=> !fifoCtl.txClear)
        else $error("transmit clear held");
    chk_dma_gated: assert property (fifoCtl.dmaMode |-> fifoCtl.fifoEnable)
        else $error("dma mode without fifo");
    chk_trig_legal: assert property (fifoCtl.rxTrigger inside {5'h01, 5'h04, 5'h08, 5'h0E})
        else $error("bad trigger level");
    chk_data_bits: assert property (fifoCtl.dataBits == 4'h5 + {2'h0, fifoCtl.lineFormat[1:0]})
        else $error("bad data bits");
    chk_enable_upper: assert property (rdIe |=> prdata[7:4] == 4'h0)
        else $error("enable upper bits set");
    chk_id_high: assert property (rdId |=> prdata[5:4] == 2'h0 && prdata[7:6] == {2{fifoCtl.fifoEnable}})
        else $error("ident high bits wrong");
    chk_id_bit3: assert property (rdId |=> (!prdata[3] || prdata[2:0] == 3'h4)
        && (fifoCtl.fifoEnable || !prdata[3]))
        else $error("ident bit 3 wrong");
    chk_id_code: assert property (rdId |=> prdata[3:0] inside {4'h1, 4'h6, 4'h4, 4'hC, 4'h2, 4'h0})
        else $error("ident code illegal");
    chk_toggle_clr: assert property ($changed(fifoCtl.fifoEnable) |-> $past(fifoCtl.rxClear) && $past(fifoCtl.txClear))
        else $error("enable change without clears");
    cover property (rdId ##1 prdata[3:0] == 4'hC);
    cover property (fifoCtl.dmaMode);
    cover property (irqOutput);
endmodule
bind uic_interrupt_fifo_control uic_ifc_chk u_chk (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .fifoCtl(fifoCtl), .irqOutput(irqOutput));
`default_nettype wire

// *** sim/uic_tb.sv ***
// Self-checking bench for the serial channel interrupt and FIFO control.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] ID = uic_pkg::IDENT_ADDR;
    localparam logic [11:0] IE = uic_pkg::IEN_ADDR;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, irqOutput, rxDma, txDma, txEmpty;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [6:0] pulseReq;
    uic_pkg::uic_chan_evt_s chanEvt;
    uic_pkg::uic_fifo_ctl_s fifoCtl;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    int txClrSeen = 0;
    uic_interrupt_fifo_control uut (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chanEvt(chanEvt),
        .fifoCtl(fifoCtl), .irqOutput(irqOutput), .rxDmaRequest(rxDma), .txDmaRequest(txDma));
    uic_chan_model partner (.clk(clk), .rst(rst), .pulseReq(pulseReq), .txEmpty(txEmpty), .txFull(1'b0),
        .rxClear(fifoCtl.rxClear), .evt(chanEvt));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (fifoCtl.txClear === 1'b1) txClrSeen <= txClrSeen + 1;
    end
    task automatic end_sim;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] r, output logic e);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            chk("bus answer", 8'h01, 8'h00);
            end_sim();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        repeat (2) @(negedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string nm);
        logic [7:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        chk(nm, exp, r);
    endtask
    task automatic pulse(input int k);
        @(posedge clk);
        pulseReq <= 7'h01 << k;
        @(posedge clk);
        pulseReq <= 7'h00;
        repeat (3) @(negedge clk);
    endtask
    task automatic t_regs;
        logic [7:0] r;
        logic e;
        rd(ID, 8'h01, "ident after reset");
        wr(IE, 8'hFF);
        rd(IE, 8'h0F, "enable upper bits");
        for (int i = 3; i >= 0; i--) begin
            wr(uic_pkg::LFC_ADDR, 8'hA4 | 8'(i));
            rd(uic_pkg::LFC_ADDR, 8'hA4 | 8'(i), "line format");
            chk("data bits", 8'(5 + i), {4'h0, fifoCtl.dataBits});
        end
        apb(1'b0, 12'h010, 8'h00, r, e);
        chk("unmapped error", 8'h01, {7'h0, e});
    endtask
    task automatic t_fifo;
        logic [4:0] lv[4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
        int tc;
        for (int i = 0; i < 4; i++) begin
            wr(ID, {2'(i), 6'h01});
            chk("trigger", {3'h0, lv[i]}, {3'h0, fifoCtl.rxTrigger});
        end
        wr(ID, 8'hC9);
        chk("dma mode", 8'h01, {7'h0, fifoCtl.dmaMode});
        chk("tx dma", 8'h01, {7'h0, txDma});
        pulse(6);
        chk("rx dma below trigger", 8'h00, {7'h0, rxDma});
        wr(ID, 8'hCB);
        chk("rx cleared", 8'h00, {3'h0, chanEvt.rxCount});
        tc = txClrSeen;
        wr(ID, 8'hC5);
        chk("tx clear count", 8'(tc + 1), 8'(txClrSeen));
        wr(ID, 8'h08);
        chk("fifo off", 8'h00, {6'h0, fifoCtl.fifoEnable, fifoCtl.dmaMode});
        rd(ID, 8'h01, "legacy ident");
    endtask
    task automatic t_prio;
        wr(IE, 8'h0F);
        @(posedge clk);
        txEmpty <= 1'b1;
        repeat (3) @(negedge clk);
        chk("irq tx empty", 8'h01, {7'h0, irqOutput});
        pulse(6);
        chk("rx dma legacy", 8'h01, {7'h0, rxDma});
        rd(ID, 8'h04, "data over tx");
        pulse(4);
        rd(ID, 8'h06, "line over data");
        pulse(3);
        rd(ID, 8'h04, "line cleared");
        pulse(5);
        rd(ID, 8'h02, "data cleared");
        rd(ID, 8'h01, "tx cleared by read");
        pulse(2);
        rd(ID, 8'h00, "modem pending");
        wr(IE, 8'h00);
        @(negedge clk);
        chk("irq masked", 8'h00, {7'h0, irqOutput});
        wr(IE, 8'h08);
        @(negedge clk);
        chk("irq modem", 8'h01, {7'h0, irqOutput});
        pulse(1);
        rd(ID, 8'h01, "modem cleared");
        wr(IE, 8'h0F);
        @(posedge clk);
        txEmpty <= 1'b0;
        pulse(0);
        @(posedge clk);
        txEmpty <= 1'b1;
        pulse(0);
        chk("tx cleared by write", 8'h00, {7'h0, irqOutput});
    endtask
    task automatic t_timeout;
        int n = 0;
        int t0;
        logic [7:0] r;
        logic e;
        wr(IE, 8'h01);
        wr(ID, 8'hC1);
        pulse(6);
        t0 = cyc;
        rd(ID, 8'hC1, "below trigger");
        do begin
            apb(1'b0, ID, 8'h00, r, e);
            n++;
        end while (r !== 8'hCC && n < 100);
        chk("timeout code", 8'hCC, r);
        chk("timeout delay", 8'h01, {7'h0, (cyc - t0) >= 108 && (cyc - t0) <= 124});
        if (n >= 100) end_sim();
        pulse(5);
        rd(ID, 8'hC1, "timeout cleared");
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pulseReq = 7'h00;
        txEmpty = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_fifo();
        t_prio();
        t_timeout();
        end_sim();
    end
endmodule
`default_nettype wire
